// [inc/bcso_pkg.sv]
// bcso_pkg: constants, types and reset image for the sequencer op block.
// assumes one 100 MHz clock domain shared with the sequencer and RAM arbiter.
package bcso_pkg;

  // register indices; byte address on the bus is four times the index
  localparam logic [7:0]  REG_TTNM_IDX  = 8'h36;
  localparam logic [7:0]  REG_FLAG_IDX  = 8'h37;
  localparam logic [7:0]  REG_QPTR_IDX  = 8'h38;
  localparam logic [7:0]  REG_CTRL_IDX  = 8'h39;

  localparam logic [15:0] QPTR_RESET    = 16'h00c0;
  localparam logic [15:0] WPTR_RESET    = 16'h0050;
  localparam logic [15:0] WPTR_LIMIT    = 16'h004f;
  localparam logic [15:0] FLAG_RESET    = 16'h0000;
  localparam logic [15:0] CTRL_RESET    = 16'h0000;
  localparam logic [15:0] ZERO_WORD     = 16'h0000;
  localparam logic [15:0] ONE_WORD      = 16'h0001;
  localparam logic [15:0] QUEUE_SPAN    = 16'h003f;

  // control register fields
  localparam int unsigned CTRL_QIRQ_BIT = 13;
  localparam int unsigned CTRL_T32_BIT  = 0;

  // message block word offsets
  localparam logic [15:0] BLK_TTNM_OFS  = 16'h0003;
  localparam logic [15:0] BLK_TAG_OFS   = 16'h0004;
  localparam logic [15:0] BLK_W7_OFS    = 16'h0006;

  // op codes
  localparam logic [4:0]  OP_FLAG       = 5'h0c;
  localparam logic [4:0]  OP_XEQ        = 5'h10;
  localparam logic [4:0]  OP_XQG        = 5'h11;
  localparam logic [4:0]  OP_XQF        = 5'h15;
  localparam logic [4:0]  OP_XFG        = 5'h17;
  localparam logic [4:0]  OP_WMP        = 5'h1b;
  localparam logic [4:0]  OP_WMI        = 5'h1c;
  localparam logic [4:0]  OP_DSZ        = 5'h1d;

  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_HOLD = 4'h1,
    S_TTRD = 4'h3,
    S_TTWT = 4'h2,
    S_TAGS = 4'h6,
    S_RUN  = 4'h7,
    S_TAGE = 4'h5,
    S_DRD  = 4'h8,
    S_DWT  = 4'hc
  } bcso_state_e;

  typedef struct packed {
    logic [4:0]  opcode;
    logic        condTrue;
    logic [15:0] param;
  } bcso_op_s;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [15:0] addr;
    logic [15:0] wdata;
  } bcso_ram_s;

  typedef struct packed {
    bcso_state_e state;
    logic [15:0] wptr;
    logic [15:0] qptr;
    logic [15:0] qbase;
    logic [15:0] flag;
    logic [15:0] ctrl;
    logic [15:0] ttnm;
    logic [15:0] blk;
    bcso_ram_s   ram;
    logic        opReady;
    logic        opDone;
    logic        skipNext;
    logic        msgStart;
    logic        pushTaken;
    logic        queueIrq;
    logic        ack;
    logic [31:0] datO;
  } bcso_regs_s;

  localparam bcso_regs_s REGS_RESET = '{
    state: S_IDLE, wptr: WPTR_RESET, qptr: QPTR_RESET, qbase: QPTR_RESET,
    flag: FLAG_RESET, ctrl: CTRL_RESET, ttnm: ZERO_WORD, blk: ZERO_WORD,
    ram: '{req: 1'b0, we: 1'b0, addr: ZERO_WORD, wdata: ZERO_WORD},
    opReady: 1'b1, opDone: 1'b0, skipNext: 1'b0, msgStart: 1'b0,
    pushTaken: 1'b0, queueIrq: 1'b0, ack: 1'b0, datO: 32'h0000_0000};

endpackage

// [rtl/bcso_core.sv]
// bcso_core: pointer/immediate writes, decrement-skip, flag ops, queue pushes
// and message block bookkeeping of the bus controller sequencer.
// assumes RAM takes a request every cycle and returns read data one cycle
// after the cycle in which the request stood; sequencer shares mclk.
//
// Implementation choice: the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none

// Contract
// - true write-pointer op loads hidden pointer
// - pointer ignores values not above 0x4f
// - hidden pointer resets to 0x0050
// - write-immediate stores value at pointer
// - false condition only advances sequencer; flag and execute ops here run regardless of it
// - decrement RAM word, skip next if zero
// - flag op modifies low eight flag bits
// - 64-word circular queue in RAM
// - queue pointer resets 0x00c0, host may move
// - push writes at pointer then advances
// - pointer wraps to base every 64th word
// - wrap with enable raises controller interrupt
// - execute ops take parameter as block address
// - normal block is eight words
// - RT-to-RT block is sixteen words
// - time-to-next holds off the next message
// - time tag written at start and end
// - 32-bit base: high time bits in word seven
// - 16-bit base: last transmitted word in seven
// - data pointer used only for data commands
// - RT-to-RT word one receive, eighth tx status
// - nonzero time-to-next copied to timer, counts
module bcso_core (
  input  wire logic              mclk,
  input  wire logic              rst_b,
  input  wire logic [9:0]        adr_i,
  input  wire logic [31:0]       dat_i,
  input  wire logic              we_i,
  input  wire logic [3:0]        sel_i,
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  output logic                   ack_o,
  output logic [31:0]            dat_o,
  input  wire logic              opValid,
  input  wire bcso_pkg::bcso_op_s opIn,
  output logic                   opReady,
  output logic                   opDone,
  output logic                   skipNext,
  input  wire logic              pushValid,
  input  wire logic [15:0]       pushData,
  output logic                   pushTaken,
  output bcso_pkg::bcso_ram_s    ramOut,
  input  wire logic [15:0]       ramRdata,
  input  wire logic [31:0]       timeTag,
  input  wire logic              timerTick,
  output logic                   msgStart,
  output logic [15:0]            msgAddr,
  input  wire logic              msgEnd,
  input  wire logic [15:0]       lastTxWord,
  output logic                   queueIrq
);

  bcso_pkg::bcso_regs_s s;
  bcso_pkg::bcso_regs_s n;

  logic       opTake;
  logic       pushTake;
  logic       hostRd;
  logic       hostWr;
  logic [7:0] regIdx;
  logic       time32;
  logic       qWrap;

  // each argument pair comes from bit i of the high and low parameter bytes
  function automatic logic [7:0] bcsoFlagApply(input logic [7:0]  cur,
                                                input logic [15:0] arg);
    logic [7:0] res;
    res = cur;
    for (int i = 0; i < 8; i++) begin
      case ({arg[8+i], arg[i]})
        2'b01:   res[i] = 1'b1;
        2'b10:   res[i] = 1'b0;
        2'b11:   res[i] = ~cur[i];
        default: res[i] = cur[i];
      endcase
    end
    return res;
  endfunction

  // byte-lane merge of a host write into a 16-bit register
  function automatic logic [15:0] bcsoLaneMerge(input logic [15:0] cur,
                                                input logic [31:0] wd,
                                                input logic [3:0]  sel);
    logic [15:0] res;
    res = cur;
    if (sel[0]) begin
      res[7:0] = wd[7:0];
    end
    if (sel[1]) begin
      res[15:8] = wd[15:8];
    end
    return res;
  endfunction

  function automatic logic bcsoIsExec(input logic [4:0] op);
    return (op == bcso_pkg::OP_XEQ) || (op == bcso_pkg::OP_XQG) ||
           (op == bcso_pkg::OP_XQF) || (op == bcso_pkg::OP_XFG);
  endfunction

  assign regIdx   = adr_i[9:2];
  assign hostRd   = cyc_i && stb_i && !s.ack;
  assign hostWr   = cyc_i && stb_i && s.ack && we_i;
  assign opTake   = opValid && (s.state == bcso_pkg::S_IDLE);
  assign pushTake = pushValid && !opValid && (s.state == bcso_pkg::S_IDLE);
  assign time32   = s.ctrl[bcso_pkg::CTRL_T32_BIT];
  assign qWrap    = (s.qptr == s.qbase + bcso_pkg::QUEUE_SPAN);

  always_comb begin
    n           = s;
    n.ram.req   = 1'b0;
    n.ram.we    = 1'b0;
    n.opDone    = 1'b0;
    n.skipNext  = 1'b0;
    n.msgStart  = 1'b0;
    n.pushTaken = 1'b0;
    n.queueIrq  = 1'b0;
    n.ack       = hostRd;
    n.datO      = 32'h0000_0000;

    // unmapped indices answer with zero data
    if (hostRd) begin
      case (regIdx)
        bcso_pkg::REG_TTNM_IDX: n.datO[15:0] = s.ttnm;
        bcso_pkg::REG_FLAG_IDX: n.datO[15:0] = s.flag;
        bcso_pkg::REG_QPTR_IDX: n.datO[15:0] = s.qptr;
        bcso_pkg::REG_CTRL_IDX: n.datO[15:0] = s.ctrl;
        default:                n.datO       = 32'h0000_0000;
      endcase
    end

    // write takes effect at the edge the master sees ack
    if (hostWr) begin
      case (regIdx)
        bcso_pkg::REG_FLAG_IDX: n.flag = bcsoLaneMerge(s.flag, dat_i, sel_i);
        bcso_pkg::REG_QPTR_IDX: begin
          n.qptr  = bcsoLaneMerge(s.qptr, dat_i, sel_i);
          n.qbase = n.qptr;
        end
        bcso_pkg::REG_CTRL_IDX: n.ctrl = bcsoLaneMerge(s.ctrl, dat_i, sel_i);
        default: ;
      endcase
    end

    if (timerTick && (s.ttnm != bcso_pkg::ZERO_WORD)) begin
      n.ttnm = s.ttnm - bcso_pkg::ONE_WORD;
    end

    case (s.state)
      bcso_pkg::S_IDLE: begin
        if (opTake) begin
          case (opIn.opcode)
            bcso_pkg::OP_WMP: begin
              if (opIn.condTrue && (opIn.param > bcso_pkg::WPTR_LIMIT)) begin
                n.wptr = opIn.param;
              end
            end
            bcso_pkg::OP_WMI: begin
              if (opIn.condTrue) begin
                n.ram.req   = 1'b1;
                n.ram.we    = 1'b1;
                n.ram.addr  = s.wptr;
                n.ram.wdata = opIn.param;
              end
            end
            bcso_pkg::OP_DSZ: begin
              if (opIn.condTrue) begin
                n.ram.req  = 1'b1;
                n.ram.addr = opIn.param;
                n.blk      = opIn.param;
                n.state    = bcso_pkg::S_DRD;
              end
            end
            bcso_pkg::OP_FLAG: begin
              n.flag[7:0] = bcsoFlagApply(s.flag[7:0], opIn.param);
            end
            default: begin
              if (bcsoIsExec(opIn.opcode)) begin
                n.blk   = opIn.param;
                n.state = bcso_pkg::S_HOLD;
              end
            end
          endcase
          // false pointer, immediate and decrement conditions fall through here with no other effect
          n.opDone = (n.state == bcso_pkg::S_IDLE);
        end else if (pushTake) begin
          n.ram.req   = 1'b1;
          n.ram.we    = 1'b1;
          n.ram.addr  = s.qptr;
          n.ram.wdata = pushData;
          n.pushTaken = 1'b1;
          // a push in the same cycle as a host pointer write wins
          if (qWrap) begin
            n.qptr     = s.qbase;
            n.queueIrq = s.ctrl[bcso_pkg::CTRL_QIRQ_BIT];
          end else begin
            n.qptr = s.qptr + bcso_pkg::ONE_WORD;
          end
        end
      end
      bcso_pkg::S_HOLD: begin
        // the previous message's countdown must expire first
        if (s.ttnm == bcso_pkg::ZERO_WORD) begin
          n.ram.req  = 1'b1;
          n.ram.addr = s.blk + bcso_pkg::BLK_TTNM_OFS;
          n.state    = bcso_pkg::S_TTRD;
        end
      end
      bcso_pkg::S_TTRD: begin
        n.state = bcso_pkg::S_TTWT;
      end
      bcso_pkg::S_TTWT: begin
        if (ramRdata != bcso_pkg::ZERO_WORD) begin
          n.ttnm = ramRdata;
        end
        n.ram.req   = 1'b1;
        n.ram.we    = 1'b1;
        n.ram.addr  = s.blk + bcso_pkg::BLK_TAG_OFS;
        n.ram.wdata = timeTag[15:0];
        n.state     = bcso_pkg::S_TAGS;
      end
      bcso_pkg::S_TAGS: begin
        if (time32) begin
          n.ram.req   = 1'b1;
          n.ram.we    = 1'b1;
          n.ram.addr  = s.blk + bcso_pkg::BLK_W7_OFS;
          n.ram.wdata = timeTag[31:16];
        end
        // engine handles command, data pointer and status words
        n.msgStart = 1'b1;
        n.state    = bcso_pkg::S_RUN;
      end
      bcso_pkg::S_RUN: begin
        if (msgEnd) begin
          n.ram.req   = 1'b1;
          n.ram.we    = 1'b1;
          n.ram.addr  = s.blk + bcso_pkg::BLK_TAG_OFS;
          n.ram.wdata = timeTag[15:0];
          n.state     = bcso_pkg::S_TAGE;
        end
      end
      bcso_pkg::S_TAGE: begin
        n.ram.req   = 1'b1;
        n.ram.we    = 1'b1;
        n.ram.addr  = s.blk + bcso_pkg::BLK_W7_OFS;
        n.ram.wdata = time32 ? timeTag[31:16] : lastTxWord;
        n.opDone    = 1'b1;
        n.state     = bcso_pkg::S_IDLE;
      end
      bcso_pkg::S_DRD: begin
        n.state = bcso_pkg::S_DWT;
      end
      bcso_pkg::S_DWT: begin
        n.ram.req   = 1'b1;
        n.ram.we    = 1'b1;
        n.ram.addr  = s.blk;
        n.ram.wdata = ramRdata - bcso_pkg::ONE_WORD;
        n.skipNext  = (ramRdata == bcso_pkg::ONE_WORD);
        n.opDone    = 1'b1;
        n.state     = bcso_pkg::S_IDLE;
      end
      default: begin
        n.state = bcso_pkg::S_IDLE;
      end
    endcase

    n.opReady = (n.state == bcso_pkg::S_IDLE);
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      s <= bcso_pkg::REGS_RESET;
    end else begin
      s <= n;
    end
  end

  assign ack_o     = s.ack;
  assign dat_o     = s.datO;
  assign opReady   = s.opReady;
  assign opDone    = s.opDone;
  assign skipNext  = s.skipNext;
  assign pushTaken = s.pushTaken;
  assign ramOut    = s.ram;
  assign msgStart  = s.msgStart;
  assign msgAddr   = s.blk;
  assign queueIrq  = s.queueIrq;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  wptr_load_a: assert property (
    opTake && opIn.opcode == bcso_pkg::OP_WMP && opIn.condTrue &&
    opIn.param > bcso_pkg::WPTR_LIMIT |=> s.wptr == $past(opIn.param))
    else $error("write pointer not loaded");

  wptr_keep_a: assert property (
    opTake && opIn.opcode == bcso_pkg::OP_WMP &&
    opIn.param <= bcso_pkg::WPTR_LIMIT |=> $stable(s.wptr))
    else $error("write pointer changed by low value");

  wptr_reset_a: assert property (
    $rose(rst_b) |-> s.wptr == bcso_pkg::WPTR_RESET &&
    s.qptr == bcso_pkg::QPTR_RESET)
    else $error("pointer reset value wrong");

  wmi_store_a: assert property (
    opTake && opIn.opcode == bcso_pkg::OP_WMI && opIn.condTrue |=>
    ramOut.req && ramOut.we && ramOut.addr == $past(s.wptr) &&
    ramOut.wdata == $past(opIn.param))
    else $error("immediate not written at pointer");

  false_cond_a: assert property (
    opTake && !opIn.condTrue && (opIn.opcode == bcso_pkg::OP_WMI ||
    opIn.opcode == bcso_pkg::OP_DSZ) |=> opDone && !ramOut.req && opReady)
    else $error("false condition had an effect");

  dsz_skip_a: assert property (
    opTake && opIn.opcode == bcso_pkg::OP_DSZ && opIn.condTrue |=>
    ##2 opDone && ramOut.we && skipNext == (ramOut.wdata == 16'h0000))
    else $error("decrement skip wrong");

  // written per bit from the argument table, independent of the function
  flag_mod_a: assert property (
    opTake && opIn.opcode == bcso_pkg::OP_FLAG && !hostWr |=>
    s.flag[7:0] == ((($past(s.flag[7:0]) | $past(opIn.param[7:0])) &
                     ~$past(opIn.param[15:8])) |
                    ($past(opIn.param[15:8]) & $past(opIn.param[7:0]) &
                     ~$past(s.flag[7:0]))))
    else $error("flag bits wrong");

  push_addr_a: assert property (
    pushTake |=> pushTaken && ramOut.we && ramOut.addr == $past(s.qptr))
    else $error("push not at queue pointer");

  queue_wrap_a: assert property (
    pushTake && qWrap && s.ctrl[bcso_pkg::CTRL_QIRQ_BIT] |=>
    queueIrq && s.qptr == $past(s.qbase))
    else $error("queue wrap without interrupt");

  ttnm_load_a: assert property (
    s.state == bcso_pkg::S_TTWT && ramRdata != 16'h0000 |=>
    s.ttnm == $past(ramRdata) ##1 msgStart)
    else $error("timer not loaded from block");

  tag_start_a: assert property (
    s.state == bcso_pkg::S_TTWT |=> ramOut.we &&
    ramOut.addr == s.blk + bcso_pkg::BLK_TAG_OFS)
    else $error("start time tag missing");

endmodule

`default_nettype wire

// [tb/bcso_ram_model.sv]
// bcso_ram_model: shared RAM behind the op block, one-cycle read latency.
// assumes ramOut.req is a one-cycle pulse launched on mclk.
`timescale 1ns/10ps
`default_nettype none
module bcso_ram_model (
  input  wire logic                mclk,
  input  wire bcso_pkg::bcso_ram_s ramOut,
  output logic [15:0]              ramRdata
);
  // message blocks and the queue are plain words here
  logic [15:0] mem [0:65535];
  logic [15:0] rdq;
  logic        rdValid;

  always @(posedge mclk) begin
    rdValid <= ramOut.req && !ramOut.we;
    if (ramOut.req && ramOut.we) begin
      mem[ramOut.addr] <= ramOut.wdata;
    end
    if (ramOut.req && !ramOut.we) begin
      rdq <= mem[ramOut.addr];
    end
  end
  // stale read data flips so a late sample cannot pass
  assign ramRdata = rdValid ? rdq : ~rdq;
endmodule
`default_nettype wire

// [tb/test_bus_controller_sequencer_ops.sv]
// test_bus_controller_sequencer_ops: register, op, queue and message runs.
// assumes the RAM model answers reads one cycle after the request.
`timescale 1ns/10ps
`default_nettype none
module test_bus_controller_sequencer_ops;
  logic                mclk;
  logic                rst_b;
  logic [9:0]          adr_i;
  logic [31:0]         dat_i;
  logic                we_i;
  logic [3:0]          sel_i;
  logic                cyc_i;
  logic                stb_i;
  logic                ack_o;
  logic [31:0]         dat_o;
  logic                opValid;
  bcso_pkg::bcso_op_s  opIn;
  logic                opReady;
  logic                opDone;
  logic                skipNext;
  logic                pushValid;
  logic [15:0]         pushData;
  logic                pushTaken;
  bcso_pkg::bcso_ram_s ramOut;
  logic [15:0]         ramRdata;
  logic [31:0]         timeTag;
  logic                msgStart;
  logic [15:0]         msgAddr;
  logic                msgEnd;
  logic                queueIrq;
  logic                timerTick;
  logic [15:0]         lastTxWord;
  int                  errors;
  int                  compares;
  logic [15:0]         rd;
  logic                sk;

  bcso_core dut (
    .mclk(mclk), .rst_b(rst_b), .adr_i(adr_i), .dat_i(dat_i), .we_i(we_i),
    .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .dat_o(dat_o),
    .opValid(opValid), .opIn(opIn), .opReady(opReady), .opDone(opDone),
    .skipNext(skipNext), .pushValid(pushValid), .pushData(pushData),
    .pushTaken(pushTaken), .ramOut(ramOut), .ramRdata(ramRdata),
    .timeTag(timeTag), .timerTick(timerTick), .msgStart(msgStart), .msgAddr(msgAddr),
    .msgEnd(msgEnd), .lastTxWord(lastTxWord), .queueIrq(queueIrq)
  );
  bcso_ram_model ram (.mclk(mclk), .ramOut(ramOut), .ramRdata(ramRdata));

  task automatic tally_and_finish();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic hang(input string what);
    errors++;
    $display("[FAIL] %s expected answer seen timeout", what);
    tally_and_finish();
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // classic single cycle; ack is read as it stood before the edge
  task automatic wb(input logic w, input logic [9:0] a, input logic [15:0] d);
    int n;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    sel_i <= 4'h3;
    adr_i <= a;
    dat_i <= {16'h0000, d};
    for (n = 0; n < 20; n++) begin
      @(posedge mclk);
      if (ack_o === 1'b1) break;
    end
    if (n == 20) hang("bus ack");
    rd = dat_o[15:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
    @(posedge mclk);
  endtask

  // extra edge at the end lets the final RAM write land
  task automatic op(input logic [4:0] code, input logic c, input logic [15:0] p);
    int n;
    opValid <= 1'b1;
    opIn    <= '{opcode: code, condTrue: c, param: p};
    for (n = 0; n < 20; n++) begin
      @(posedge mclk);
      if (opReady === 1'b1) break;
    end
    if (n == 20) hang("op ready");
    opValid <= 1'b0;
    for (n = 0; n < 200; n++) begin
      @(posedge mclk);
      if (opDone === 1'b1) break;
    end
    if (n == 200) hang("op done");
    sk = skipNext;
    @(posedge mclk);
  endtask

  task automatic push(input logic [15:0] d, output logic irq);
    pushValid <= 1'b1;
    pushData  <= d;
    @(posedge mclk);
    pushValid <= 1'b0;
    @(posedge mclk);
    chk("push taken", 16'h0001, {15'h0000, pushTaken});
    irq = queueIrq;
  endtask

  // engine side of one message: wait for start, check it, then end it
  task automatic msgRun(input logic [15:0] a, input logic [31:0] endTime);
    int n;
    for (n = 0; n < 50; n++) begin
      @(posedge mclk);
      if (msgStart === 1'b1) break;
    end
    if (n == 50) hang("message start");
    chk("message address", a, msgAddr);
    chk("start tag", timeTag[15:0], ram.mem[a + 16'h0004]);
    timeTag <= endTime;
    msgEnd  <= 1'b1;
    @(posedge mclk);
    msgEnd  <= 1'b0;
  endtask

  function automatic logic [15:0] flagExp(input logic [15:0] f, input logic [15:0] p);
    logic [15:0] r;
    r = f;
    for (int b = 0; b < 8; b++) begin
      case ({p[b + 8], p[b]})
        2'b01: r[b] = 1'b1;
        2'b10: r[b] = 1'b0;
        2'b11: r[b] = ~f[b];
        default: r[b] = f[b];
      endcase
    end
    return r;
  endfunction

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  initial begin
    logic irq;
    int   i;
    {rst_b, adr_i, dat_i, we_i, cyc_i, stb_i, opValid, pushValid, msgEnd} = '0;
    opIn = '0;
    pushData = 16'h0000;
    timeTag = 32'h1234_5678;
    sel_i = 4'h0;
    timerTick = 1'b0;
    lastTxWord = 16'h0000;
    errors = 0;
    compares = 0;
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    wb(1'b0, 10'h0e0, 16'h0000);
    chk("queue pointer reset", 16'h00c0, rd);
    wb(1'b1, 10'h3fc, 16'h1234);
    wb(1'b0, 10'h3fc, 16'h0000);
    chk("unmapped read", 16'h0000, rd);
    op(bcso_pkg::OP_WMI, 1'b1, 16'h1111);
    chk("immediate at reset pointer", 16'h1111, ram.mem[16'h0050]);
    op(bcso_pkg::OP_WMP, 1'b1, 16'h004f);
    op(bcso_pkg::OP_WMI, 1'b1, 16'h2222);
    chk("pointer at limit kept", 16'h2222, ram.mem[16'h0050]);
    op(bcso_pkg::OP_WMP, 1'b1, 16'h0123);
    op(bcso_pkg::OP_WMP, 1'b0, 16'h0200);
    op(bcso_pkg::OP_WMI, 1'b1, 16'h3333);
    chk("pointer loaded", 16'h3333, ram.mem[16'h0123]);
    op(bcso_pkg::OP_WMI, 1'b0, 16'h4444);
    chk("false immediate", 16'h3333, ram.mem[16'h0123]);
    ram.mem[16'h0300] = 16'h0002;
    op(bcso_pkg::OP_DSZ, 1'b1, 16'h0300);
    chk("decrement to one", 16'h0001, ram.mem[16'h0300]);
    chk("no skip", 16'h0000, {15'h0000, sk});
    op(bcso_pkg::OP_DSZ, 1'b1, 16'h0300);
    chk("decrement to zero", 16'h0000, ram.mem[16'h0300]);
    chk("skip", 16'h0001, {15'h0000, sk});
    op(bcso_pkg::OP_DSZ, 1'b0, 16'h0300);
    chk("false decrement", 16'h0000, ram.mem[16'h0300]);
    chk("false no skip", 16'h0000, {15'h0000, sk});
    // flag op ignores the condition; parameter covers all four codes
    wb(1'b1, 10'h0dc, 16'ha5cc);
    op(bcso_pkg::OP_FLAG, 1'b0, 16'h3c5a);
    wb(1'b0, 10'h0dc, 16'h0000);
    chk("flags", flagExp(16'ha5cc, 16'h3c5a), rd);
    wb(1'b1, 10'h0e0, 16'h0400);
    wb(1'b1, 10'h0e4, 16'h2001);
    for (i = 0; i < 64; i++) begin
      push(16'h0a00 + 16'(i), irq);
      chk("queue irq", {15'h0000, i == 63}, {15'h0000, irq});
    end
    // last push lands in RAM one edge after it was taken
    @(posedge mclk);
    for (i = 0; i < 64; i++) begin
      chk("queue word", 16'h0a00 + 16'(i), ram.mem[16'h0400 + 16'(i)]);
    end
    wb(1'b0, 10'h0e0, 16'h0000);
    chk("pointer wrapped", 16'h0400, rd);
    push(16'h0b00, irq);
    @(posedge mclk);
    chk("write after wrap", 16'h0b00, ram.mem[16'h0400]);
    ram.mem[16'h0503] = 16'h0000;
    ram.mem[16'h0504] = 16'h0000;
    ram.mem[16'h0506] = 16'h0000;
    fork
      op(bcso_pkg::OP_XEQ, 1'b1, 16'h0500);
      msgRun(16'h0500, 32'h1234_9abc);
    join
    chk("end tag", 16'h9abc, ram.mem[16'h0504]);
    chk("upper time bits", 16'h1234, ram.mem[16'h0506]);
    // 16-bit time base and a nonzero countdown in the block
    wb(1'b1, 10'h0e4, 16'h2000);
    lastTxWord <= 16'h5a5a;
    ram.mem[16'h0603] = 16'h0003;
    ram.mem[16'h0606] = 16'h0000;
    fork
      op(bcso_pkg::OP_XEQ, 1'b1, 16'h0600);
      msgRun(16'h0600, 32'h0000_4321);
    join
    chk("loopback word", 16'h5a5a, ram.mem[16'h0606]);
    wb(1'b0, 10'h0d8, 16'h0000);
    chk("timer loaded", 16'h0003, rd);
    ram.mem[16'h0504] = 16'h0000;
    fork
      op(bcso_pkg::OP_XEQ, 1'b1, 16'h0500);
      begin
        repeat (8) @(posedge mclk);
        chk("held by timer", 16'h0000, ram.mem[16'h0504]);
        timerTick <= 1'b1;
        repeat (3) @(posedge mclk);
        timerTick <= 1'b0;
        msgRun(16'h0500, 32'h0000_0042);
      end
    join
    chk("end tag after hold", 16'h0042, ram.mem[16'h0504]);
    wb(1'b0, 10'h0d8, 16'h0000);
    chk("timer expired", 16'h0000, rd);
    tally_and_finish();
  end
endmodule
`default_nettype wire
